//--- design/asrp_host.sv
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module asrp_host (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    asrp_if.host lnk
);
    import asrp_pkg::*;

    asrp_hstate_t state_r;
    asrp_hstate_t state_nxt;
    logic cs_r;
    logic cs_nxt;
    logic sclk_r;
    logic sclk_nxt;
    logic fs_r;
    logic fs_nxt;
    logic dsp_r;
    logic dsp_nxt;
    logic conv_r;
    logic conv_nxt;
    logic cap_r;
    logic cap_nxt;
    logic done_r;
    logic done_nxt;
    logic tmo_r;
    logic tmo_nxt;
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_nxt;
    logic [CNT_W-1:0] nb_r;
    logic [CNT_W-1:0] nb_nxt;
    logic [WAIT_W-1:0] wt_r;
    logic [WAIT_W-1:0] wt_nxt;
    logic [WORD_W-1:0] data_r;
    logic [WORD_W-1:0] data_nxt;
    logic wait_r;
    logic wait_nxt;
    logic [31:0] rd_r;
    logic [31:0] rd_nxt;
    logic dout_q;
    logic fso_q;
    logic tick;
    logic cmd_wr;
    logic [31:0] status;

    asrp_sync #(.RST_VAL(1'b0)) u_dout (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(lnk.dout_line),
        .q(dout_q),
        .rise(),
        .fall()
    );

    asrp_sync #(.RST_VAL(1'b0)) u_fso (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(lnk.fs_out),
        .q(fso_q),
        .rise(),
        .fall()
    );

    // Serial clock from the host's own clock by division
    assign tick = (state_r != H_IDLE) && (div_r == DIV_LAST);
    assign cmd_wr = avs_write && !wait_r && (avs_address == CTRL_OFS);
    assign status = {28'h0000000, tmo_r, done_r, dsp_r,
        state_r != H_IDLE};

    always_comb begin
        wait_nxt = 1'b1;
        rd_nxt = rd_r;
        if ((avs_read || avs_write) && wait_r) begin
            wait_nxt = 1'b0;
            if (avs_address == STAT_OFS) begin
                rd_nxt = status;
            end else if (avs_address == DATA_OFS) begin
                rd_nxt = {8'h00, data_r};
            end else begin
                rd_nxt = RD_ZERO;
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        cs_nxt = cs_r;
        sclk_nxt = sclk_r;
        fs_nxt = fs_r;
        dsp_nxt = dsp_r;
        conv_nxt = conv_r;
        cap_nxt = cap_r;
        done_nxt = done_r;
        tmo_nxt = tmo_r;
        nb_nxt = nb_r;
        wt_nxt = wt_r;
        data_nxt = data_r;
        div_nxt = (state_r == H_IDLE || tick) ? 4'h0 : div_r + 1'b1;
        case (state_r)
            H_IDLE: begin
                if (cmd_wr && avs_writedata[CTRL_READ_BIT] && !dsp_r) begin
                    cs_nxt = 1'b0;
                    conv_nxt = 1'b0;
                    state_nxt = H_LEAD;
                    done_nxt = 1'b0;
                    tmo_nxt = 1'b0;
                    nb_nxt = 5'h00;
                    data_nxt = 24'h000000;
                end else if (cmd_wr && avs_writedata[CTRL_DSP_ON_BIT] &&
                             !dsp_r) begin
                    // Frame sync goes low a half period ahead of select
                    fs_nxt = 1'b0;
                    conv_nxt = 1'b0;
                    state_nxt = H_LEAD;
                    done_nxt = 1'b0;
                    tmo_nxt = 1'b0;
                    dsp_nxt = 1'b1;
                end else if (cmd_wr && avs_writedata[CTRL_CONV_BIT] &&
                             dsp_r) begin
                    fs_nxt = 1'b1;
                    conv_nxt = 1'b1;
                    cap_nxt = 1'b0;
                    state_nxt = H_RUN;
                    done_nxt = 1'b0;
                    tmo_nxt = 1'b0;
                    nb_nxt = 5'h00;
                    wt_nxt = 6'h00;
                    data_nxt = 24'h000000;
                end else if (cmd_wr && avs_writedata[CTRL_DSP_OFF_BIT] &&
                             dsp_r) begin
                    cs_nxt = 1'b1;
                    fs_nxt = 1'b1;
                    dsp_nxt = 1'b0;
                end
            end
            H_LEAD: begin
                if (tick) begin
                    if (dsp_r) begin
                        // Select then stays low for the whole DSP session
                        cs_nxt = 1'b0;
                        done_nxt = 1'b1;
                        state_nxt = H_IDLE;
                    end else begin
                        state_nxt = H_RUN;
                    end
                end
            end
            H_RUN: begin
                if (tick) begin
                    sclk_nxt = ~sclk_r;
                    if (!sclk_r) begin
                        if (!conv_r) begin
                            data_nxt = {data_r[WORD_W-2:0], dout_q};
                            nb_nxt = nb_r + 1'b1;
                        end else if (cap_r || fso_q) begin
                            cap_nxt = 1'b1;
                            data_nxt = {data_r[WORD_W-2:0], dout_q};
                            nb_nxt = nb_r + 1'b1;
                        end else begin
                            wt_nxt = wt_r + 1'b1;
                        end
                    end else begin
                        if (conv_r) begin
                            fs_nxt = 1'b0;
                        end
                        if (!conv_r && nb_r == STD_BITS) begin
                            state_nxt = H_TAIL;
                        end else if (conv_r && nb_r == DSP_BITS) begin
                            done_nxt = 1'b1;
                            state_nxt = H_IDLE;
                        end else if (conv_r && wt_r == FSO_WAIT_MAX) begin
                            tmo_nxt = 1'b1;
                            done_nxt = 1'b1;
                            state_nxt = H_IDLE;
                        end
                    end
                end
            end
            H_TAIL: begin
                if (tick) begin
                    cs_nxt = 1'b1;
                    done_nxt = 1'b1;
                    state_nxt = H_IDLE;
                end
            end
            default: begin
                state_nxt = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wait_r <= 1'b1;
            rd_r <= RD_ZERO;
            state_r <= H_IDLE;
            cs_r <= 1'b1;
            sclk_r <= 1'b0;
            fs_r <= 1'b1;
            dsp_r <= 1'b0;
            conv_r <= 1'b0;
            cap_r <= 1'b0;
            done_r <= 1'b0;
            tmo_r <= 1'b0;
            div_r <= 4'h0;
            nb_r <= 5'h00;
            wt_r <= 6'h00;
            data_r <= 24'h000000;
        end else begin
            wait_r <= wait_nxt;
            rd_r <= rd_nxt;
            state_r <= state_nxt;
            cs_r <= cs_nxt;
            sclk_r <= sclk_nxt;
            fs_r <= fs_nxt;
            dsp_r <= dsp_nxt;
            conv_r <= conv_nxt;
            cap_r <= cap_nxt;
            done_r <= done_nxt;
            tmo_r <= tmo_nxt;
            div_r <= div_nxt;
            nb_r <= nb_nxt;
            wt_r <= wt_nxt;
            data_r <= data_nxt;
        end
    end

    assign lnk.cs_n = cs_r;
    assign lnk.sclk = sclk_r;
    assign lnk.fs_in = fs_r;
    assign avs_readdata = rd_r;
    assign avs_waitrequest = wait_r;
endmodule : asrp_host
`default_nettype wire

//--- design/asrp_pkg.sv
package asrp_pkg;
    localparam int CLK_KHZ = 40000;
    // Fastest serial clock the device accepts
    localparam int SCLK_MAX_KHZ = 4800;
    // Host rate kept well under the limit to cover both synchronisers
    localparam int HOST_SCLK_KHZ = 2500;
    localparam int SCLK_MIN_HALF_CYC =
        (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
    localparam int HOST_HALF_CYC =
        (CLK_KHZ + 2 * HOST_SCLK_KHZ - 1) / (2 * HOST_SCLK_KHZ);
    localparam int SCLK_HALF_CYC = (HOST_HALF_CYC > SCLK_MIN_HALF_CYC) ?
        HOST_HALF_CYC : SCLK_MIN_HALF_CYC;

    localparam int RES_W = 16;
    localparam int FRAME_W = 8;
    localparam int FRAMES = 3;
    localparam int WORD_W = FRAME_W * FRAMES;
    localparam int LEAD_ZEROS = WORD_W - RES_W - 2;
    localparam int CNT_W = 5;
    localparam int DIV_W = 4;
    localparam int WAIT_W = 6;
    localparam logic [CNT_W-1:0] STD_BITS = CNT_W'(WORD_W);
    localparam logic [CNT_W-1:0] DSP_BITS = CNT_W'(RES_W + 2);
    localparam logic [CNT_W-1:0] MSB_CNT = CNT_W'(LEAD_ZEROS);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF_CYC - 1);
    localparam logic [WAIT_W-1:0] FSO_WAIT_MAX = 6'h28;

    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] DATA_OFS = 4'h8;
    localparam int CTRL_READ_BIT = 0;
    localparam int CTRL_DSP_ON_BIT = 1;
    localparam int CTRL_CONV_BIT = 2;
    localparam int CTRL_DSP_OFF_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DSP_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_TMO_BIT = 3;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [3:0] {
        D_IDLE = 4'b0001,
        D_STD = 4'b0010,
        D_DSP_WAIT = 4'b0100,
        D_DSP_SHIFT = 4'b1000
    } asrp_dstate_t;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_LEAD = 4'b0010,
        H_RUN = 4'b0100,
        H_TAIL = 4'b1000
    } asrp_hstate_t;
endpackage : asrp_pkg

//--- design/asrp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface asrp_if;
    logic cs_n;
    logic sclk;
    logic fs_in;
    logic fs_out;
    logic dout_o;
    logic dout_oe;
    logic dout_line;

    // Undriven data line reads low
    assign dout_line = dout_oe & dout_o;

    modport dev (
        input cs_n,
        input sclk,
        input fs_in,
        output fs_out,
        output dout_o,
        output dout_oe
    );

    modport host (
        output cs_n,
        output sclk,
        output fs_in,
        input fs_out,
        input dout_line
    );
endinterface : asrp_if
`default_nettype wire

//--- design/asrp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asrp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic d,
    output logic q,
    output logic rise,
    output logic fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic s1_nxt;
    logic s2_nxt;
    logic s3_nxt;

    always_comb begin
        s1_nxt = d;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    assign q = s2_r;
    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;
endmodule : asrp_sync
`default_nettype wire

//--- design/asrp_device.sv
// Overview of operation
// - Host runs clock idle low, mode zero.
// - Chip select low wakes device first.
// - Host reads three bytes per result; in DSP mode the host keeps only 18 bits, from the MSB.
// - Data output changes only on falling clock.
// - Host samples data on rising clock.
// - First byte frame holds leading zeros.
// - Second frame carries upper result bits.
// - Third frame: low bits, then trailer bits.
// - Serial clock up to 4.8 MHz.
// - DSP mode only with external clock.
// - Host supplies chip select falling edge.
// - Frame sync low at select selects DSP.
// - DSP mode persists while select stays low.
// - Frame sync pulse starts a conversion.
// - Output frame sync marks MSB present.
// - Host pulses frame sync per conversion.
// - Scan sequencing off during DSP mode.
// - Host clock from DSP's own oscillator.
`timescale 1ns/1ps
`default_nettype none
module asrp_device (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [asrp_pkg::RES_W-1:0] sample_data,
    input wire logic trailer_bit_high,
    input wire logic trailer_bit_low,
    input wire logic ext_clk_mode,
    output logic awake,
    output logic dsp_active,
    output logic scan_enable,
    output logic conv_start,
    asrp_if.dev lnk
);
    import asrp_pkg::*;

    asrp_dstate_t state_r;
    asrp_dstate_t state_nxt;
    logic [WORD_W-1:0] word_r;
    logic [WORD_W-1:0] word_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic dout_r;
    logic dout_nxt;
    logic oe_r;
    logic oe_nxt;
    logic fso_r;
    logic fso_nxt;
    logic awake_r;
    logic awake_nxt;
    logic dsp_r;
    logic dsp_nxt;
    logic scan_r;
    logic scan_nxt;
    logic conv_r;
    logic conv_nxt;
    logic cs_rise;
    logic cs_fall;
    logic sclk_fall;
    logic fs_q;
    logic fs_rise;

    // Zero padding ahead of the result doubles as conversion time
    function automatic logic [WORD_W-1:0] build_word(
        input logic [RES_W-1:0] res,
        input logic th,
        input logic tl
    );
        build_word = {{LEAD_ZEROS{1'b0}}, res, th, tl};
    endfunction : build_word

    function automatic logic bit_at(
        input logic [WORD_W-1:0] w,
        input logic [CNT_W-1:0] n
    );
        bit_at = w[WORD_W - 1 - int'(n)];
    endfunction : bit_at

    // Oversampling at 40 MHz keeps up with the fastest serial clock
    asrp_sync #(.RST_VAL(1'b1)) u_cs (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(lnk.cs_n),
        .q(),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    asrp_sync #(.RST_VAL(1'b0)) u_sclk (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(lnk.sclk),
        .q(),
        .rise(),
        .fall(sclk_fall)
    );

    asrp_sync #(.RST_VAL(1'b1)) u_fs (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(lnk.fs_in),
        .q(fs_q),
        .rise(fs_rise),
        .fall()
    );

    always_comb begin
        state_nxt = state_r;
        word_nxt = word_r;
        cnt_nxt = cnt_r;
        dout_nxt = dout_r;
        oe_nxt = oe_r;
        fso_nxt = fso_r;
        awake_nxt = awake_r;
        dsp_nxt = dsp_r;
        conv_nxt = 1'b0;
        if (cs_rise) begin
            state_nxt = D_IDLE;
            oe_nxt = 1'b0;
            dout_nxt = 1'b0;
            fso_nxt = 1'b0;
            awake_nxt = 1'b0;
            dsp_nxt = 1'b0;
        end else if (cs_fall) begin
            awake_nxt = 1'b1;
            oe_nxt = 1'b1;
            dout_nxt = 1'b0;
            fso_nxt = 1'b0;
            if (!fs_q && ext_clk_mode) begin
                dsp_nxt = 1'b1;
                state_nxt = D_DSP_WAIT;
            end else begin
                dsp_nxt = 1'b0;
                state_nxt = D_STD;
                word_nxt = build_word(sample_data, trailer_bit_high,
                    trailer_bit_low);
                // First bit is a zero already on the line
                cnt_nxt = 5'h01;
                conv_nxt = 1'b1;
            end
        end else begin
            case (state_r)
                D_STD: begin
                    if (sclk_fall) begin
                        if (cnt_r < STD_BITS) begin
                            dout_nxt = bit_at(word_r, cnt_r);
                            cnt_nxt = cnt_r + 1'b1;
                        end else begin
                            dout_nxt = 1'b0;
                        end
                    end
                end
                D_DSP_WAIT: begin
                    if (fs_rise) begin
                        word_nxt = build_word(sample_data, trailer_bit_high,
                            trailer_bit_low);
                        cnt_nxt = 5'h00;
                        conv_nxt = 1'b1;
                        state_nxt = D_DSP_SHIFT;
                    end
                end
                D_DSP_SHIFT: begin
                    // A new pulse mid-word restarts the conversion
                    if (fs_rise) begin
                        word_nxt = build_word(sample_data, trailer_bit_high,
                            trailer_bit_low);
                        cnt_nxt = 5'h00;
                        conv_nxt = 1'b1;
                    end else if (sclk_fall) begin
                        if (cnt_r < STD_BITS) begin
                            dout_nxt = bit_at(word_r, cnt_r);
                            fso_nxt = (cnt_r == MSB_CNT);
                            cnt_nxt = cnt_r + 1'b1;
                        end else begin
                            dout_nxt = 1'b0;
                            fso_nxt = 1'b0;
                            state_nxt = D_DSP_WAIT;
                        end
                    end
                end
                default: begin
                    state_nxt = D_IDLE;
                end
            endcase
        end
        scan_nxt = awake_nxt & ~dsp_nxt;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= D_IDLE;
            word_r <= 24'h000000;
            cnt_r <= 5'h00;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
            fso_r <= 1'b0;
            awake_r <= 1'b0;
            dsp_r <= 1'b0;
            scan_r <= 1'b0;
            conv_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            word_r <= word_nxt;
            cnt_r <= cnt_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            fso_r <= fso_nxt;
            awake_r <= awake_nxt;
            dsp_r <= dsp_nxt;
            scan_r <= scan_nxt;
            conv_r <= conv_nxt;
        end
    end

    assign lnk.dout_o = dout_r;
    assign lnk.dout_oe = oe_r;
    assign lnk.fs_out = fso_r;
    assign awake = awake_r;
    assign dsp_active = dsp_r;
    assign scan_enable = scan_r;
    assign conv_start = conv_r;
endmodule : asrp_device
`default_nettype wire

//--- dv/asrp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module asrp_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic fs_in,
    input wire logic fs_out,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic dout_line,
    input wire logic ext_clk_mode
);
    logic cs_q_r, sclk_q_r, dsp_r, dsp_nxt;
    logic [4:0] rise_r, rise_nxt;

    // Mode is latched the same way the device decides it, at select fall
    always_comb begin
        dsp_nxt = dsp_r;
        rise_nxt = rise_r;
        if (cs_n) begin
            dsp_nxt = 1'b0;
            rise_nxt = 5'h00;
        end else begin
            if (cs_q_r) dsp_nxt = !fs_in && ext_clk_mode;
            if (sclk && !sclk_q_r && rise_r != 5'h1f) begin
                rise_nxt = rise_r + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_q_r <= 1'b1;
            sclk_q_r <= 1'b0;
            dsp_r <= 1'b0;
            rise_r <= 5'h00;
        end else begin
            cs_q_r <= cs_n;
            sclk_q_r <= sclk;
            dsp_r <= dsp_nxt;
            rise_r <= rise_nxt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_dout_on_fall: assert property (
        $changed(dout_o) && dout_oe && $past(dout_oe) |->
            !sclk && !$past(sclk))
        else $error("data output moved outside a low clock phase");
    a_release_high: assert property (
        cs_n [*6] |-> !dout_oe)
        else $error("data output still driven with select high");
    a_drive_low: assert property (
        !cs_n [*6] |-> dout_oe)
        else $error("data output not driven with select low");
    a_start_zero: assert property (
        $fell(cs_n) |-> ##[2:6] (dout_oe && !dout_o))
        else $error("word did not restart after select fall");
    a_lead_zeros: assert property (
        sclk && !sclk_q_r && !cs_n && !dsp_r && rise_r < 5'd6 |-> !dout_line)
        else $error("leading bit of frame one not zero");
    a_fso_width: assert property (
        $rose(fs_out) |-> fs_out [*8] ##[1:12] !fs_out)
        else $error("frame sync out pulse width wrong");
    a_fso_dsp_only: assert property (
        fs_out |-> !cs_n && dsp_r && dout_oe)
        else $error("frame sync out outside frame sync mode");
    a_fso_after_start: assert property (
        $rose(fs_in) && dsp_r && !cs_n |-> ##[16:400] $rose(fs_out))
        else $error("no frame sync out after conversion start");
endmodule : asrp_monitor
`default_nettype wire

//--- dv/adc_serial_readout_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_port_tb;
    import asrp_pkg::*;
    typedef struct packed {
        logic [15:0] s;
        logic th;
        logic tl;
        logic [23:0] w;
    } asrp_row_t;
    logic clk, sys_rst, th, tl, ext, rd, wr, wrq;
    logic awake, dsp_active, scan_enable, conv_start;
    logic [15:0] smp;
    logic [3:0] adr;
    logic [31:0] wd, rdata, q;
    logic [23:0] cap;
    int bad_count, n_compared, n_conv, seen_scan, c0;
    // Expected word: six zeros, result MSB first, then both trailer bits
    asrp_row_t rows [4] = '{
        '{16'hffff, 1'b0, 1'b1, 24'h03fffd},
        '{16'h8001, 1'b1, 1'b0, 24'h020006},
        '{16'h5a3c, 1'b1, 1'b1, 24'h0168f3},
        '{16'h0000, 1'b0, 1'b0, 24'h000000}};

    asrp_if lnk_if();
    asrp_device asrp_device_i(.clk(clk), .sys_rst(sys_rst), .sample_data(smp),
        .trailer_bit_high(th), .trailer_bit_low(tl), .ext_clk_mode(ext),
        .awake(awake), .dsp_active(dsp_active), .scan_enable(scan_enable),
        .conv_start(conv_start), .lnk(lnk_if));
    asrp_host asrp_host_i(.clk(clk), .sys_rst(sys_rst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdata), .avs_waitrequest(wrq), .lnk(lnk_if));
    asrp_monitor asrp_monitor_i(.clk(clk), .sys_rst(sys_rst),
        .cs_n(lnk_if.cs_n), .sclk(lnk_if.sclk), .fs_in(lnk_if.fs_in),
        .fs_out(lnk_if.fs_out), .dout_o(lnk_if.dout_o),
        .dout_oe(lnk_if.dout_oe), .dout_line(lnk_if.dout_line),
        .ext_clk_mode(ext));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Our own copy of what the wire carried, taken as the host would
    always @(posedge lnk_if.sclk) begin
        if (!lnk_if.cs_n) begin
            cap <= {cap[22:0], lnk_if.dout_line};
        end
    end
    always @(posedge clk) begin
        if (conv_start === 1'b1) n_conv++;
        if (scan_enable === 1'b1) seen_scan = 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic av(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wrq !== 1'b0 && n < 50);
        q = rdata;
        if (n >= 50) begin
            bad_count++;
            $display("ERROR t=%0t wait got=%h exp=%h", $time, wrq, 1'b0);
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : av

    task automatic poll();
        int n;
        n = 0;
        do begin
            av(1'b0, STAT_OFS, 32'h0);
            n++;
        end while ((q[STAT_DONE_BIT] !== 1'b1 ||
            q[STAT_BUSY_BIT] !== 1'b0) && n < 300);
        if (n >= 300) begin
            bad_count++;
            $display("ERROR t=%0t poll got=%h exp=%h", $time, q, 32'h4);
        end
    endtask : poll

    task print_verdict();
        $display("errors %0d compared %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        sys_rst = 1'b1;
        smp = 16'h0;
        th = 1'b0;
        tl = 1'b0;
        ext = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 4'h0;
        wd = 32'h0;
        cap = 24'h0;
        bad_count = 0;
        n_compared = 0;
        n_conv = 0;
        seen_scan = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            @(posedge clk);
            smp <= rows[i].s;
            th <= rows[i].th;
            tl <= rows[i].tl;
            c0 = n_conv;
            av(1'b1, CTRL_OFS, 32'h1);
            poll();
            chk(32'(cap), 32'(rows[i].w));
            chk(32'(n_conv - c0), 32'h1);
            chk(32'({lnk_if.sclk, lnk_if.cs_n}), 32'h1);
            av(1'b0, DATA_OFS, 32'h0);
            chk(q, 32'(rows[i].w));
        end
        chk(32'(seen_scan), 32'h1);
        av(1'b0, 4'hc, 32'h0);
        chk(q, RD_ZERO);
        av(1'b0, CTRL_OFS, 32'h0);
        chk(q, RD_ZERO);
        // Frame sync mode: enter, two conversions back to back, refusal, exit
        @(posedge clk) ext <= 1'b1;
        av(1'b1, CTRL_OFS, 32'h2);
        poll();
        chk(32'({dsp_active, scan_enable, awake}), 32'h5);
        chk(32'(lnk_if.cs_n), 32'h0);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            smp <= rows[j].s;
            th <= rows[j].th;
            tl <= rows[j].tl;
            av(1'b1, CTRL_OFS, 32'h4);
            poll();
            chk(32'({q[STAT_TMO_BIT], lnk_if.cs_n}), 32'h0);
            av(1'b0, DATA_OFS, 32'h0);
            chk(q, 32'(rows[j].w));
        end
        av(1'b1, CTRL_OFS, 32'h1);
        av(1'b0, STAT_OFS, 32'h0);
        chk(32'(q[3:0]), 32'h6);
        av(1'b1, CTRL_OFS, 32'h8);
        av(1'b0, STAT_OFS, 32'h0);
        av(1'b0, STAT_OFS, 32'h0);
        chk(32'({dsp_active, q[STAT_DSP_BIT]}), 32'h0);
        // Without external clock mode the device must not take frame sync mode
        @(posedge clk) ext <= 1'b0;
        av(1'b1, CTRL_OFS, 32'h2);
        poll();
        chk(32'(dsp_active), 32'h0);
        av(1'b1, CTRL_OFS, 32'h4);
        poll();
        chk(32'(q[STAT_TMO_BIT]), 32'h1);
        av(1'b1, CTRL_OFS, 32'h8);
        // Reset in the middle of a word, then a clean word again
        av(1'b1, CTRL_OFS, 32'h1);
        repeat (60) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(32'({lnk_if.cs_n, awake, lnk_if.dout_oe}), 32'h4);
        av(1'b0, STAT_OFS, 32'h0);
        chk(q, RD_ZERO);
        av(1'b1, CTRL_OFS, 32'h1);
        poll();
        chk(32'(cap), 32'(rows[1].w));
        print_verdict();
    end

    initial begin
        #1_250_000;
        bad_count++;
        $display("ERROR t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
        print_verdict();
    end
endmodule : adc_serial_readout_port_tb
`default_nettype wire
